//--- bench/eeprom_i2c_target_front_end_bench.sv
`timescale 1ns/10ps
module eeprom_i2c_target_front_end_bench import eit_pkg::*;;
  logic i_mclk, i_reset_n, inhibit, cmd_valid, rd_ack, rej;
  logic [2:0] strap;
  logic [7:0] tx_data, wdata, rx_data, rdata;
  eit_cmd_e cmd_c;
  logic ready, selected, read_mode, rx_valid, tx_load, wr_rej, wr_busy;
  logic cmd_ready, done, ack_seen, in_txn, ack;
  int n_fail, tests_run;
  logic [2:0] open_strap;
  int n_sel, n_load, n_rxv;

  eit_bus_if u_eit_bus_if ();
  eit_bus_if u_eit_bus_if_b ();

  // Target and controller facing each other
  eit_target #(.POWERUP_CYC(600), .WRITE_CYC(1000)) u_eit_target (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .bus(u_eit_bus_if),
    .i_select_strap_bit0(strap[0]), .i_select_strap_bit1(strap[1]),
    .i_select_strap_bit2(strap[2]), .i_write_inhibit(inhibit), .i_tx_data(tx_data),
    .o_ready(ready), .o_selected(selected), .o_read_mode(read_mode), .o_rx_data(rx_data),
    .o_rx_valid(rx_valid), .o_tx_load(tx_load), .o_write_rejected(wr_rej),
    .o_write_busy(wr_busy));
  eit_controller #(.QTR_CYC(8)) u_eit_controller (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .bus(u_eit_bus_if), .i_cmd_valid(cmd_valid),
    .i_cmd(cmd_c), .i_wdata(wdata), .i_rd_ack(rd_ack), .o_cmd_ready(cmd_ready),
    .o_done(done), .o_rdata(rdata), .o_ack_seen(ack_seen), .o_in_txn(in_txn));
  // Second target on a bus the bench drives by hand: four-contact variant, open straps low, then 3'h6
  eit_target #(.POWERUP_CYC(600), .FOUR_CONTACT(1'b1)) u_eit_target_b (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .bus(u_eit_bus_if_b),
    .i_select_strap_bit0(open_strap[0]), .i_select_strap_bit1(open_strap[1]),
    .i_select_strap_bit2(open_strap[2]), .i_write_inhibit(inhibit), .i_tx_data(tx_data),
    .o_ready(), .o_selected(), .o_read_mode(),
    .o_rx_data(), .o_rx_valid(), .o_tx_load(), .o_write_rejected(), .o_write_busy());
  eit_checker u_eit_checker (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .ctl_scl_o(u_eit_bus_if.ctl_scl_o),
    .ctl_scl_oe(u_eit_bus_if.ctl_scl_oe), .ctl_sda_o(u_eit_bus_if.ctl_sda_o),
    .ctl_sda_oe(u_eit_bus_if.ctl_sda_oe), .tgt_sda_o(u_eit_bus_if.tgt_sda_o),
    .tgt_sda_oe(u_eit_bus_if.tgt_sda_oe), .scl(u_eit_bus_if.scl), .sda(u_eit_bus_if.sda));

  // System clock
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end

  // Sticky record of a rejected write, and counts of the target's pulses
  always @(posedge i_mclk) begin
    if (wr_rej === 1'b1) rej <= 1'b1;
    if (selected === 1'b1) n_sel <= n_sel + 1;
    if (tx_load === 1'b1) n_load <= n_load + 1;
    if (rx_valid === 1'b1) n_rxv <= n_rxv + 1;
  end

  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One controller command, held until taken, then wait for completion
  task automatic cmd(input eit_cmd_e c, input logic [7:0] d, input logic ra);
    int n;
    n = 0;
    cmd_valid = 1'b1;
    cmd_c = c;
    wdata = d;
    rd_ack = ra;
    while (cmd_ready !== 1'b1 && n < 2000) begin
      step(1);
      n++;
    end
    step(1);
    cmd_valid = 1'b0;
    while (done !== 1'b1 && n < 4000) begin
      step(1);
      n++;
    end
    chk(8'(done), 8'h01);
  endtask

  task automatic wr(input logic [7:0] d, input logic exp_ack);
    cmd(CMD_WRITE, d, 1'b0);
    chk(8'(ack_seen), 8'(exp_ack));
  endtask

  task automatic wait_ready;
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 2000) begin
      step(1);
      n++;
    end
    chk(8'(ready), 8'h01);
  endtask

  // Hand-driven bits on the second bus, clock low on entry and exit
  task automatic bb_byte(input logic [7:0] b, input int nb, output logic a);
    a = 1'b0;
    for (int i = 0; i < nb; i++) begin
      u_eit_bus_if_b.ctl_sda_oe = (i < 8) ? ~b[7-i] : 1'b0;
      step(10);
      u_eit_bus_if_b.ctl_scl_oe = 1'b0;
      step(10);
      if (i == 8) a = ~u_eit_bus_if_b.sda;
      u_eit_bus_if_b.ctl_scl_oe = 1'b1;
      step(10);
    end
  endtask

  task automatic bb_start;
    u_eit_bus_if_b.ctl_sda_oe = 1'b0;
    step(10);
    u_eit_bus_if_b.ctl_scl_oe = 1'b0;
    step(10);
    u_eit_bus_if_b.ctl_sda_oe = 1'b1;
    step(10);
    u_eit_bus_if_b.ctl_scl_oe = 1'b1;
    step(10);
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (40000) @(posedge i_mclk);
    n_fail++;
    $display("[ERR] %0t watchdog got %h exp %h", $time, 1'b0, 1'b1);
    final_report();
  end

  // Main sequence
  initial begin
    i_reset_n = 1'b0;
    strap = 3'h5;
    inhibit = 1'b0;
    tx_data = 8'hC3;
    cmd_valid = 1'b0;
    cmd_c = CMD_START;
    wdata = 8'h00;
    rd_ack = 1'b0;
    rej = 1'b0;
    open_strap = 3'h0;
    n_sel = 0;
    n_load = 0;
    n_rxv = 0;
    n_fail = 0;
    tests_run = 0;
    u_eit_bus_if_b.ctl_scl_o = 1'b0;
    u_eit_bus_if_b.ctl_sda_o = 1'b0;
    u_eit_bus_if_b.ctl_scl_oe = 1'b0;
    u_eit_bus_if_b.ctl_sda_oe = 1'b0;
    step(8);
    i_reset_n = 1'b1;
    cmd(CMD_START, 8'h00, 1'b0);
    wr(8'hAA, 1'b0);
    cmd(CMD_STOP, 8'h00, 1'b0);
    chk(8'(ready), 8'h00);
    wait_ready();
    $display("test powerup done");
    cmd(CMD_START, 8'h00, 1'b0);
    wr(8'hA0, 1'b0);
    cmd(CMD_START, 8'h00, 1'b0);
    wr(8'h50, 1'b0);
    cmd(CMD_START, 8'h00, 1'b0);
    wr(8'hAA, 1'b1);
    chk(8'(read_mode), 8'h00);
    wr(8'h01, 1'b1);
    wr(8'h23, 1'b1);
    wr(8'h5A, 1'b1);
    chk(rx_data, 8'h5A);
    cmd(CMD_STOP, 8'h00, 1'b0);
    chk(8'(wr_busy), 8'h01);
    chk(8'(in_txn), 8'h00);
    cmd(CMD_START, 8'h00, 1'b0);
    wr(8'hAA, 1'b0);
    cmd(CMD_STOP, 8'h00, 1'b0);
    $display("test write done");
    i_reset_n = 1'b0;
    step(2);
    chk(8'(wr_busy), 8'h00);
    chk(8'(ready), 8'h00);
    i_reset_n = 1'b1;
    wait_ready();
    $display("test brownout done");
    inhibit = 1'b1;
    cmd(CMD_START, 8'h00, 1'b0);
    wr(8'hAA, 1'b1);
    wr(8'h01, 1'b1);
    wr(8'h23, 1'b1);
    wr(8'h5A, 1'b0);
    cmd(CMD_STOP, 8'h00, 1'b0);
    chk(8'(wr_busy), 8'h00);
    chk(8'(rej), 8'h01);
    inhibit = 1'b0;
    $display("test inhibit done");
    cmd(CMD_START, 8'h00, 1'b0);
    wr(8'hAB, 1'b1);
    chk(8'(read_mode), 8'h01);
    cmd(CMD_READ, 8'h00, 1'b1);
    chk(rdata, 8'hC3);
    tx_data = 8'h3C;
    cmd(CMD_READ, 8'h00, 1'b0);
    chk(rdata, 8'h3C);
    cmd(CMD_STOP, 8'h00, 1'b0);
    chk(8'(n_sel), 8'h03);
    chk(8'(n_rxv), 8'h05);
    chk(8'(n_load), 8'h02);
    $display("test read done");
    u_eit_bus_if_b.ctl_sda_oe = 1'b1;
    step(2);
    u_eit_bus_if_b.ctl_sda_oe = 1'b0;
    step(10);
    u_eit_bus_if_b.ctl_scl_oe = 1'b1;
    step(10);
    bb_byte(8'hA0, 9, ack);
    chk(8'(ack), 8'h00);
    bb_start();
    bb_byte(8'hA0, 9, ack);
    chk(8'(ack), 8'h01);
    open_strap = 3'h6;
    bb_byte(8'hFF, 3, ack);
    bb_start();
    bb_byte(8'hA0, 9, ack);
    chk(8'(ack), 8'h01);
    $display("test second bus done");
    final_report();
  end
endmodule // eeprom_i2c_target_front_end_bench

//--- bench/eit_checker.sv
`timescale 1ns/10ps
module eit_checker (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic ctl_scl_o,
  input wire logic ctl_scl_oe,
  input wire logic ctl_sda_o,
  input wire logic ctl_sda_oe,
  input wire logic tgt_sda_o,
  input wire logic tgt_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q, sda_q, seen, first, tgt_tx;
  logic [3:0] cnt;
  logic [7:0] addr;
  wire start_ev = scl && scl_q && sda_q && !sda;
  wire stop_ev = scl && scl_q && !sda_q && sda;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);

  // Previous line levels for edge finding
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // Bit count, address byte and direction of the current byte
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      seen <= 1'b0;
      first <= 1'b0;
      tgt_tx <= 1'b0;
      cnt <= 4'h0;
      addr <= 8'h00;
    end else if (start_ev) begin
      seen <= 1'b1;
      first <= 1'b1;
      tgt_tx <= 1'b0;
      cnt <= 4'h0;
    end else if (stop_ev) begin
      seen <= 1'b0;
      tgt_tx <= 1'b0;
    end else if (scl && !scl_q) begin
      if (cnt == 4'h8) begin
        cnt <= 4'h0;
        first <= 1'b0;
        tgt_tx <= first ? (addr[0] && !sda) : (tgt_tx && !sda);
      end else begin
        cnt <= cnt + 4'h1;
        addr <= {addr[6:0], sda};
      end
    end
  end

  sequence s_start;
    scl && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $rose(sda);
  endsequence
  sequence s_ninth;
    $rose(scl) && cnt == 4'h8;
  endsequence

  a_tgt_open_drain: assert property (tgt_sda_oe |-> !tgt_sda_o)
    else $error("target drives data line high");
  a_ctl_open_drain: assert property (ctl_sda_oe |-> !ctl_sda_o)
    else $error("controller drives data line high");
  a_clock_owner: assert property (scl == !ctl_scl_oe)
    else $error("clock line not set by controller alone");
  a_tgt_stable_high: assert property ($changed(tgt_sda_oe) |-> !scl)
    else $error("target data changed while clock high");
  a_idle_quiet: assert property (!seen |-> !tgt_sda_oe)
    else $error("target drove line without a start");
  a_start_hold: assert property (s_start |-> scl [*6])
    else $error("clock fell too soon after start");
  a_stop_release: assert property (s_stop |-> (!ctl_scl_oe && !ctl_sda_oe) [*4])
    else $error("lines not released after stop");
  a_type_mismatch: assert property (s_ninth ##0 (first && addr[7:4] != 4'hA) |-> !tgt_sda_oe)
    else $error("target acked a foreign type code");
  a_ninth_tgt_rel: assert property (s_ninth ##0 tgt_tx |-> !tgt_sda_oe)
    else $error("target held line in ninth clock");
  a_ninth_ctl_rel: assert property (s_ninth ##0 !tgt_tx |-> !ctl_sda_oe)
    else $error("controller held line in ninth clock");
  a_read_ctl_off: assert property ($rose(scl) && cnt < 4'h8 && tgt_tx |-> !ctl_sda_oe)
    else $error("controller drove line during read byte");
endmodule // eit_checker

//--- rtl/eit_bus_if.sv
`timescale 1ns/10ps
interface eit_bus_if;
  logic ctl_scl_o;
  logic ctl_scl_oe;
  logic ctl_sda_o;
  logic ctl_sda_oe;
  logic tgt_sda_o;
  logic tgt_sda_oe;
  logic scl;
  logic sda;

  // Pull-up wires: any enabled driver wins, released lines read high
  assign scl = ctl_scl_oe ? ctl_scl_o : 1'b1;
  assign sda = (ctl_sda_oe ? ctl_sda_o : 1'b1) & (tgt_sda_oe ? tgt_sda_o : 1'b1);

  modport target(input scl, input sda, output tgt_sda_o, output tgt_sda_oe);
  modport controller(input scl, input sda, output ctl_scl_o, output ctl_scl_oe,
                     output ctl_sda_o, output ctl_sda_oe);
endinterface // eit_bus_if

//--- rtl/eit_controller.sv
`timescale 1ns/10ps
`include "eit_defs.svh"
module eit_controller import eit_pkg::*; #(
  parameter int QTR_CYC = `EIT_CTL_QTR_CYC
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  eit_bus_if.controller bus,
  input wire logic i_cmd_valid,
  input wire eit_cmd_e i_cmd,
  input wire logic [7:0] i_wdata,
  input wire logic i_rd_ack,
  output logic o_cmd_ready,
  output logic o_done,
  output logic [7:0] o_rdata,
  output logic o_ack_seen,
  output logic o_in_txn
);
  localparam int QW = $clog2(QTR_CYC + 1);

  if (QTR_CYC < `EIT_CTL_QTR_MIN) begin : g_bad
    $error("eit_controller: quarter period too short for target latency");
  end

  logic [1:0] s1;
  logic [1:0] s2;
  logic [QW-1:0] qcnt;
  logic tick;
  eit_ctl_state_e state;
  logic [1:0] phase;
  logic [3:0] bitn;
  logic [8:0] pattern;
  logic [8:0] rx;
  logic scl_oe;
  logic sda_oe;
  logic bus_free;

  // Synchronise wired lines (index 1 clock, 0 data)
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s1 <= 2'h3;
      s2 <= 2'h3;
    end else begin
      s1 <= {bus.scl, bus.sda};
      s2 <= s1;
    end
  end

  // Quarter-period enable
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      qcnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (qcnt == QW'(QTR_CYC - 1));
      qcnt <= (qcnt == QW'(QTR_CYC - 1)) ? '0 : qcnt + QW'(1);
    end
  end

  // new transfer only on an idle bus
  assign bus_free = s2[1] & s2[0];
  always_comb begin
    o_cmd_ready = 1'b0;
    if (state == CTL_IDLE) begin
      o_cmd_ready = (i_cmd == CMD_START) ? (o_in_txn | bus_free) : o_in_txn;
    end
  end

  // Command sequencer, one phase per quarter period
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= CTL_IDLE;
      phase <= 2'h0;
      bitn <= 4'h0;
      pattern <= 9'h000;
      rx <= 9'h000;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      o_done <= 1'b0;
      o_rdata <= 8'h00;
      o_ack_seen <= 1'b0;
      o_in_txn <= 1'b0;
    end else begin
      o_done <= 1'b0;
      case (state)
        CTL_IDLE: begin
          if (i_cmd_valid && o_cmd_ready) begin
            phase <= 2'h0;
            bitn <= 4'h0;
            case (i_cmd)
              CMD_START: state <= CTL_START;
              CMD_STOP: state <= CTL_STOP;
              CMD_WRITE: begin
                pattern <= {~i_wdata, 1'b0};
                state <= CTL_BIT;
              end
              default: begin
                pattern <= {8'h00, i_rd_ack};
                state <= CTL_BIT;
              end
            endcase
          end
        end
        CTL_START: begin
          if (tick) begin
            phase <= phase + 2'h1;
            case (phase)
              2'h0: sda_oe <= 1'b0;
              2'h1: scl_oe <= 1'b0;
              2'h2: sda_oe <= 1'b1;
              default: begin
                scl_oe <= 1'b1;
                o_in_txn <= 1'b1;
                o_done <= 1'b1;
                state <= CTL_IDLE;
              end
            endcase
          end
        end
        CTL_BIT: begin
          if (tick) begin
            phase <= phase + 2'h1;
            // data changes only while clock low
            case (phase)
              2'h0: sda_oe <= pattern[8];
              2'h1: scl_oe <= 1'b0;
              2'h2: rx <= {rx[7:0], s2[0]};
              default: begin
                scl_oe <= 1'b1;
                pattern <= {pattern[7:0], 1'b0};
                bitn <= bitn + 4'h1;
                if (bitn == `EIT_BYTE_BITS) begin
                  o_rdata <= rx[8:1];
                  o_ack_seen <= ~rx[0];
                  o_done <= 1'b1;
                  state <= CTL_IDLE;
                end
              end
            endcase
          end
        end
        CTL_STOP: begin
          if (tick) begin
            phase <= phase + 2'h1;
            case (phase)
              2'h0: sda_oe <= 1'b1;
              2'h1: scl_oe <= 1'b0;
              2'h2: sda_oe <= 1'b0;
              default: begin
                o_in_txn <= 1'b0;
                o_done <= 1'b1;
                state <= CTL_IDLE;
              end
            endcase
          end
        end
        default: state <= CTL_IDLE;
      endcase
    end
  end

  assign bus.ctl_scl_o = 1'b0;
  assign bus.ctl_scl_oe = scl_oe;
  assign bus.ctl_sda_o = 1'b0;
  assign bus.ctl_sda_oe = sda_oe;
endmodule // eit_controller

//--- rtl/eit_defs.svh
`ifndef EIT_DEFS_SVH
`define EIT_DEFS_SVH

// System clock
`define EIT_MCLK_PERIOD_NS 20
// Longest input pulse that must be rejected, and the stable run that passes
`define EIT_GLITCH_NS 50
`define EIT_GLITCH_CYC ((`EIT_GLITCH_NS + `EIT_MCLK_PERIOD_NS - 1) / `EIT_MCLK_PERIOD_NS)
`define EIT_FILT_CYC (`EIT_GLITCH_CYC + 1)
// Ready delay after supply is stable, a longest time
`define EIT_POWERUP_MS 0.35
`define EIT_POWERUP_CYC (int'(`EIT_POWERUP_MS * 1000000.0 / `EIT_MCLK_PERIOD_NS))
// Nonvolatile write cycle, a longest time
`define EIT_WRITE_MS 4
`define EIT_WRITE_CYC (int'(`EIT_WRITE_MS * 1000000.0 / `EIT_MCLK_PERIOD_NS))
// Target address layout
`define EIT_TYPE_CODE 4'hA
`define EIT_TYPE_MSB 7
`define EIT_TYPE_LSB 4
`define EIT_SEL_MSB 3
`define EIT_SEL_LSB 1
`define EIT_RW_BIT 0
`define EIT_BYTE_BITS 4'h8
// Memory address bytes ahead of the first data byte
`define EIT_MEM_ADDR_BYTES 2
// Controller quarter period of the serial clock, standard rate
`define EIT_CTL_QTR_CYC 125
`define EIT_CTL_QTR_MIN 4

`endif

//--- rtl/eit_pkg.sv
package eit_pkg;

  typedef enum logic [2:0] {
    TGT_IDLE,
    TGT_ADDR,
    TGT_ADDR_ACK,
    TGT_RX,
    TGT_RX_ACK,
    TGT_TX,
    TGT_TX_ACK
  } eit_tgt_state_e;

  typedef enum logic [1:0] {
    CTL_IDLE,
    CTL_START,
    CTL_BIT,
    CTL_STOP
  } eit_ctl_state_e;

  typedef enum logic [1:0] {
    CMD_START,
    CMD_WRITE,
    CMD_READ,
    CMD_STOP
  } eit_cmd_e;

endpackage

//--- rtl/eit_target.sv
`timescale 1ns/10ps
`include "eit_defs.svh"
module eit_target import eit_pkg::*; #(
  parameter int POWERUP_CYC = `EIT_POWERUP_CYC,
  parameter int WRITE_CYC = `EIT_WRITE_CYC,
  parameter int ADDR_BYTES = `EIT_MEM_ADDR_BYTES,
  parameter bit FOUR_CONTACT = 1'b0
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  eit_bus_if.target bus,
  input wire logic i_select_strap_bit0,
  input wire logic i_select_strap_bit1,
  input wire logic i_select_strap_bit2,
  input wire logic i_write_inhibit,
  input wire logic [7:0] i_tx_data,
  output logic o_ready,
  output logic o_selected,
  output logic o_read_mode,
  output logic [7:0] o_rx_data,
  output logic o_rx_valid,
  output logic o_tx_load,
  output logic o_write_rejected,
  output logic o_write_busy
);
  localparam int PUW = $clog2(POWERUP_CYC + 1);
  localparam int WRW = $clog2(WRITE_CYC + 1);

  if (POWERUP_CYC < 1 || WRITE_CYC < 1 || ADDR_BYTES < 0 || ADDR_BYTES > 6) begin : g_bad
    $error("eit_target: parameter out of range");
  end

  logic [1:0] pin_s1;
  logic [1:0] pin_s2;
  logic [1:0] filt;
  logic [1:0] filt_q;
  logic [2:0] fcnt [2];
  logic [3:0] strap_s1;
  logic [3:0] strap_s2;
  eit_tgt_state_e state;
  logic [3:0] bit_cnt;
  logic [7:0] rx_shift;
  logic [7:0] tx_shift;
  logic [2:0] byte_idx;
  logic sda_oe;
  logic wp_lat;
  logic host_ack;
  logic data_seen;
  logic write_kick;
  logic [PUW-1:0] pu_cnt;
  logic [WRW-1:0] wr_cnt;
  logic [2:0] sel;
  logic addr_match;
  logic reject_now;

  // Two-stage synchronisers for bus lines (index 1 clock, 0 data)
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_s1 <= 2'h3;
      pin_s2 <= 2'h3;
    end else begin
      pin_s1 <= {bus.scl, bus.sda};
      pin_s2 <= pin_s1;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_filt
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
        filt[g] <= 1'b1;
        fcnt[g] <= 3'h0;
      end else if (pin_s2[g] == filt[g]) begin
        fcnt[g] <= 3'h0;
      end else if (fcnt[g] == 3'(`EIT_FILT_CYC - 1)) begin
        filt[g] <= pin_s2[g];
        fcnt[g] <= 3'h0;
      end else begin
        fcnt[g] <= fcnt[g] + 3'h1;
      end
    end
  end

  // Previous filtered levels for edge finding
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      filt_q <= 2'h3;
    end else begin
      filt_q <= filt;
    end
  end

  wire scl_rise = filt[1] & ~filt_q[1];
  wire scl_fall = ~filt[1] & filt_q[1];
  wire start_cond = filt[1] & filt_q[1] & filt_q[0] & ~filt[0];
  wire stop_cond = filt[1] & filt_q[1] & ~filt_q[0] & filt[0];

  // Strap and inhibit pins synchronised; bench drives open pins low, then to 3'h6
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      strap_s1 <= 4'h0;
      strap_s2 <= 4'h0;
    end else begin
      strap_s1 <= {i_write_inhibit, i_select_strap_bit2, i_select_strap_bit1,
                   i_select_strap_bit0};
      strap_s2 <= strap_s1;
    end
  end

  // select value from straps or fixed zero
  assign sel = FOUR_CONTACT ? 3'h0 : strap_s2[2:0];
  // address match, refused during write cycle
  assign addr_match = (rx_shift[`EIT_TYPE_MSB:`EIT_TYPE_LSB] == `EIT_TYPE_CODE) &&
                      (rx_shift[`EIT_SEL_MSB:`EIT_SEL_LSB] == sel) && !o_write_busy;
  // first data byte refused when inhibit was sampled high
  assign reject_now = (byte_idx == 3'(ADDR_BYTES)) && wp_lat;

  // Bus protocol engine
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= TGT_IDLE;
      bit_cnt <= 4'h0;
      rx_shift <= 8'h00;
      tx_shift <= 8'h00;
      byte_idx <= 3'h0;
      sda_oe <= 1'b0;
      wp_lat <= 1'b0;
      host_ack <= 1'b0;
      data_seen <= 1'b0;
      write_kick <= 1'b0;
      o_selected <= 1'b0;
      o_read_mode <= 1'b0;
      o_rx_data <= 8'h00;
      o_rx_valid <= 1'b0;
      o_tx_load <= 1'b0;
      o_write_rejected <= 1'b0;
    end else begin
      o_selected <= 1'b0;
      o_rx_valid <= 1'b0;
      o_tx_load <= 1'b0;
      o_write_rejected <= 1'b0;
      write_kick <= 1'b0;
      if (start_cond) begin
        // start opens address phase once ready
        state <= o_ready ? TGT_ADDR : TGT_IDLE;
        bit_cnt <= 4'h0;
        byte_idx <= 3'h0;
        sda_oe <= 1'b0;
        data_seen <= 1'b0;
      end else if (stop_cond) begin
        // stop ends command; accepted data starts write cycle
        state <= TGT_IDLE;
        bit_cnt <= 4'h0;
        sda_oe <= 1'b0;
        write_kick <= data_seen;
        data_seen <= 1'b0;
      end else begin
        case (state)
          TGT_IDLE: begin
            sda_oe <= 1'b0;
          end
          TGT_ADDR: begin
            if (scl_rise) begin
              rx_shift <= {rx_shift[6:0], filt[0]};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == `EIT_BYTE_BITS) begin
              bit_cnt <= 4'h0;
              // acknowledge own address in ninth clock
              if (addr_match) begin
                sda_oe <= 1'b1;
                o_read_mode <= rx_shift[`EIT_RW_BIT];
                o_selected <= 1'b1;
                state <= TGT_ADDR_ACK;
              end else begin
                state <= TGT_IDLE;
              end
            end
          end
          TGT_ADDR_ACK: begin
            if (scl_fall) begin
              if (o_read_mode) begin
                tx_shift <= i_tx_data;
                sda_oe <= ~i_tx_data[7];
                o_tx_load <= 1'b1;
                state <= TGT_TX;
              end else begin
                sda_oe <= 1'b0;
                state <= TGT_RX;
                // strobe inhibit before first data byte
                if (ADDR_BYTES == 0) begin
                  wp_lat <= strap_s2[3];
                end
              end
            end
          end
          TGT_RX: begin
            if (scl_rise) begin
              rx_shift <= {rx_shift[6:0], filt[0]};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == `EIT_BYTE_BITS) begin
              bit_cnt <= 4'h0;
              // withhold acknowledge and drop the write
              if (reject_now) begin
                o_write_rejected <= 1'b1;
                state <= TGT_IDLE;
              end else begin
                o_rx_data <= rx_shift;
                o_rx_valid <= 1'b1;
                sda_oe <= 1'b1;
                state <= TGT_RX_ACK;
                if (byte_idx >= 3'(ADDR_BYTES)) begin
                  data_seen <= 1'b1;
                end
              end
            end
          end
          TGT_RX_ACK: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              state <= TGT_RX;
              if (byte_idx != 3'h7) begin
                byte_idx <= byte_idx + 3'h1;
              end
              // strobe inhibit on last fall before data
              if (byte_idx + 3'h1 == 3'(ADDR_BYTES)) begin
                wp_lat <= strap_s2[3];
              end
            end
          end
          TGT_TX: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt == `EIT_BYTE_BITS) begin
                sda_oe <= 1'b0;
                bit_cnt <= 4'h0;
                state <= TGT_TX_ACK;
              end else begin
                // pull low for zero, release for one
                sda_oe <= ~tx_shift[6];
                tx_shift <= {tx_shift[6:0], 1'b0};
              end
            end
          end
          TGT_TX_ACK: begin
            if (scl_rise) begin
              host_ack <= ~filt[0];
            end else if (scl_fall) begin
              if (host_ack) begin
                tx_shift <= i_tx_data;
                sda_oe <= ~i_tx_data[7];
                o_tx_load <= 1'b1;
                state <= TGT_TX;
              end else begin
                state <= TGT_IDLE;
              end
            end
          end
          default: state <= TGT_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pu_cnt <= '0;
      o_ready <= 1'b0;
    end else if (!o_ready) begin
      pu_cnt <= pu_cnt + PUW'(1);
      o_ready <= (pu_cnt == PUW'(POWERUP_CYC - 1));
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_cnt <= '0;
      o_write_busy <= 1'b0;
    end else if (write_kick) begin
      wr_cnt <= WRW'(WRITE_CYC);
      o_write_busy <= 1'b1;
    end else if (wr_cnt != '0) begin
      wr_cnt <= wr_cnt - WRW'(1);
      o_write_busy <= (wr_cnt != WRW'(1));
    end
  end

  // open-drain data only; no clock drive exists
  assign bus.tgt_sda_o = 1'b0;
  assign bus.tgt_sda_oe = sda_oe;
endmodule // eit_target
